// *** fault_sig_cfg.svh ***
// constants for the fault, break and snoop-result signalling pair
// assumes inclusion by bare name from the package and both ends
`ifndef FAULT_SIG_CFG_SVH
`define FAULT_SIG_CFG_SVH
`define PIN_ASSERTED 1'b0
`define PIN_RELEASED 1'b1
`define SNOOP_STALL_LIMIT 4'h3
`endif

// *** fault_sig_pkg.sv ***
// types used by the processor end of the fault signalling link
// assumes fault_sig_cfg.svh in the include path
`include "fault_sig_cfg.svh"
package fault_sig_pkg;
    typedef enum logic [2:0] {
        SNOOP_IDLE = 3'b001,
        SNOOP_STALL = 3'b010,
        SNOOP_DONE = 3'b100
    } snoop_state_t;
endpackage

// *** fault_sig_if.sv ***
// link wires between processor end and chipset end, all active low except shutdown_txn
// assumes one clock shared by both ends; snoop lines one pair per end, each with one driver
`timescale 1ns/1ps
`default_nettype none
interface fault_sig_if;
    logic fp_fault_or_break_pending_n;
    logic stop_clock_request_n;
    logic debug_probe_request_n;
    logic internal_fault_out_n;
    logic numeric_fault_ignore_n;
    logic bus_restart_in_n;
    logic init_n;
    logic shutdown_txn;
    logic snoop_hit_dev_n;
    logic snoop_modified_match_dev_n;
    logic snoop_hit_cs_n;
    logic snoop_modified_match_cs_n;
    modport device (
        output fp_fault_or_break_pending_n, internal_fault_out_n, shutdown_txn,
        output snoop_hit_dev_n, snoop_modified_match_dev_n,
        input stop_clock_request_n, debug_probe_request_n, numeric_fault_ignore_n,
        input bus_restart_in_n, init_n, snoop_hit_cs_n, snoop_modified_match_cs_n
    );
    modport chipset (
        input fp_fault_or_break_pending_n, internal_fault_out_n, shutdown_txn,
        input snoop_hit_dev_n, snoop_modified_match_dev_n,
        output stop_clock_request_n, debug_probe_request_n, numeric_fault_ignore_n,
        output bus_restart_in_n, init_n, snoop_hit_cs_n, snoop_modified_match_cs_n
    );
endinterface // fault_sig_if
`default_nettype wire

// *** fault_sig_device.sv ***
// processor end: fp error / break output, internal fault, snoop result
// assumes link inputs synchronous to core_clk_i
`timescale 1ns/1ps
`default_nettype none
`include "fault_sig_cfg.svh"
module fault_sig_device (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    fault_sig_if.device link,
    input wire logic fp_error_i,
    input wire logic fp_error_masked_i,
    input wire logic fp_report_mode_bit_i,
    input wire logic fp_noncontrol_op_i,
    input wire logic internal_error_i,
    input wire logic snoop_req_i,
    input wire logic snoop_hit_i,
    input wire logic snoop_modified_i,
    input wire logic snoop_busy_i,
    output logic fp_exception_o,
    output logic break_pending_o
);
    logic fp_err_reg, fp_err_next;
    logic brk_reg, brk_next;
    logic ferr_reg, ferr_next;
    logic internal_fault_out_reg, internal_fault_out_next;
    logic shut_reg, shut_next;
    logic exc_reg, exc_next;
    logic hit_reg, hit_next, snoop_modified_match_reg, snoop_modified_match_next;
    fault_sig_pkg::snoop_state_t snp_reg, snp_next;
    logic stopped, ignore_ok, restart;

    function automatic logic low(input logic pin);
        low = (pin == `PIN_ASSERTED);
    endfunction

    // fault and break next state
    always_comb begin
        stopped = low(link.stop_clock_request_n);
        restart = low(link.bus_restart_in_n) || low(link.init_n);
        // native reporting overrides ignore pin
        ignore_ok = low(link.numeric_fault_ignore_n) && !fp_report_mode_bit_i;
        fp_err_next = fp_err_reg;
        if (fp_error_i && !fp_error_masked_i) begin
            fp_err_next = 1'b1;
        end else if (fp_noncontrol_op_i && ignore_ok) begin
            fp_err_next = 1'b0;
        end
        exc_next = fp_noncontrol_op_i && fp_err_reg && !ignore_ok;
        brk_next = brk_reg;
        if (!stopped) begin
            brk_next = 1'b0;
        end else if (low(link.debug_probe_request_n)) begin
            brk_next = 1'b1;
        end else if (fp_error_i && !fp_error_masked_i) begin
            brk_next = 1'b1;
        end
        ferr_next = stopped ? brk_next : fp_err_next;
        // a new error in a restart cycle wins, so it is never lost
        internal_fault_out_next = internal_error_i || (internal_fault_out_reg && !restart);
        shut_next = internal_error_i && !internal_fault_out_reg;
    end

    // snoop result; both lines low means stall
    always_comb begin
        snp_next = snp_reg;
        hit_next = 1'b0;
        snoop_modified_match_next = 1'b0;
        case (snp_reg)
            fault_sig_pkg::SNOOP_IDLE: begin
                if (snoop_req_i) begin
                    snp_next = snoop_busy_i ? fault_sig_pkg::SNOOP_STALL
                                            : fault_sig_pkg::SNOOP_DONE;
                    hit_next = snoop_busy_i || snoop_hit_i;
                    snoop_modified_match_next = snoop_busy_i || snoop_modified_i;
                end
            end
            fault_sig_pkg::SNOOP_STALL: begin
                snp_next = snoop_busy_i ? fault_sig_pkg::SNOOP_STALL
                                        : fault_sig_pkg::SNOOP_DONE;
                hit_next = snoop_busy_i || snoop_hit_i;
                snoop_modified_match_next = snoop_busy_i || snoop_modified_i;
            end
            default: snp_next = fault_sig_pkg::SNOOP_IDLE;
        endcase
    end

    // register everything; outputs come straight from flops
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            fp_err_reg <= 1'b0;
            brk_reg <= 1'b0;
            ferr_reg <= 1'b0;
            internal_fault_out_reg <= 1'b0;
            shut_reg <= 1'b0;
            exc_reg <= 1'b0;
            hit_reg <= 1'b0;
            snoop_modified_match_reg <= 1'b0;
            snp_reg <= fault_sig_pkg::SNOOP_IDLE;
        end else begin
            fp_err_reg <= fp_err_next;
            brk_reg <= brk_next;
            ferr_reg <= ferr_next;
            internal_fault_out_reg <= internal_fault_out_next;
            shut_reg <= shut_next;
            exc_reg <= exc_next;
            hit_reg <= hit_next;
            snoop_modified_match_reg <= snoop_modified_match_next;
            snp_reg <= snp_next;
        end
    end

    assign link.fp_fault_or_break_pending_n = ~ferr_reg;
    assign link.internal_fault_out_n = ~internal_fault_out_reg;
    assign link.shutdown_txn = shut_reg;
    assign link.snoop_hit_dev_n = ~hit_reg;
    assign link.snoop_modified_match_dev_n = ~snoop_modified_match_reg;
    assign fp_exception_o = exc_reg;
    assign break_pending_o = brk_reg;
endmodule // fault_sig_device
`default_nettype wire

// *** fault_sig_chipset.sv ***
// chipset end: stop-clock control, nmi from shutdown, snoop reply
// assumes same clock as the processor end
`timescale 1ns/1ps
`default_nettype none
`include "fault_sig_cfg.svh"
module fault_sig_chipset (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    fault_sig_if.chipset link,
    input wire logic stop_req_i,
    input wire logic probe_req_i,
    input wire logic ignore_req_i,
    input wire logic restart_req_i,
    input wire logic init_req_i,
    input wire logic nmi_enable_i,
    input wire logic snoop_stall_i,
    input wire logic snoop_hit_i,
    input wire logic snoop_modified_i,
    output logic nmi_o,
    output logic fp_error_seen_o,
    output logic dev_stall_o,
    output logic internal_fault_seen_o
);
    logic stop_reg, stop_next;
    logic nmi_reg, nmi_next;
    logic ferr_reg, ferr_next;
    logic stall_reg, stall_next;
    logic internal_fault_out_reg, internal_fault_out_next;
    logic probe_reg, ign_reg, rst_reg, init_reg, hit_reg, snoop_modified_match_reg;
    logic brk_seen;
    logic hold_reg, hold_next;
    logic stop_prev_reg;

    // stop-clock dropped once break seen; re-armed when request drops
    always_comb begin
        brk_seen = stop_reg && (link.fp_fault_or_break_pending_n == `PIN_ASSERTED);
        // without this hold a still-asserted stop request would restart the stop at once
        hold_next = stop_req_i && (hold_reg || brk_seen);
        stop_next = stop_reg;
        if (brk_seen || !stop_req_i) begin
            stop_next = 1'b0;
        end else if (!stop_reg && !ferr_reg && !hold_reg) begin
            stop_next = 1'b1;
        end
        nmi_next = link.shutdown_txn && nmi_enable_i;
        // the cycle after a release still shows the break, so it is skipped
        ferr_next = !stop_reg && !stop_prev_reg
                 && (link.fp_fault_or_break_pending_n == `PIN_ASSERTED);
        stall_next = (link.snoop_hit_dev_n == `PIN_ASSERTED)
                  && (link.snoop_modified_match_dev_n == `PIN_ASSERTED);
        internal_fault_out_next = (link.internal_fault_out_n == `PIN_ASSERTED);
    end

    // registered pins and status
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            stop_reg <= 1'b0;
            nmi_reg <= 1'b0;
            ferr_reg <= 1'b0;
            stall_reg <= 1'b0;
            internal_fault_out_reg <= 1'b0;
            hold_reg <= 1'b0;
            stop_prev_reg <= 1'b0;
            probe_reg <= 1'b0;
            ign_reg <= 1'b0;
            rst_reg <= 1'b0;
            init_reg <= 1'b0;
            hit_reg <= 1'b0;
            snoop_modified_match_reg <= 1'b0;
        end else begin
            stop_reg <= stop_next;
            nmi_reg <= nmi_next;
            ferr_reg <= ferr_next;
            stall_reg <= stall_next;
            internal_fault_out_reg <= internal_fault_out_next;
            hold_reg <= hold_next;
            stop_prev_reg <= stop_reg;
            probe_reg <= probe_req_i;
            ign_reg <= ignore_req_i;
            rst_reg <= restart_req_i;
            init_reg <= init_req_i;
            hit_reg <= snoop_stall_i || snoop_hit_i;
            snoop_modified_match_reg <= snoop_stall_i || snoop_modified_i;
        end
    end

    // active-low drive of the link
    assign link.stop_clock_request_n = ~stop_reg;
    assign link.debug_probe_request_n = ~probe_reg;
    assign link.numeric_fault_ignore_n = ~ign_reg;
    assign link.bus_restart_in_n = ~rst_reg;
    assign link.init_n = ~init_reg;
    assign link.snoop_hit_cs_n = ~hit_reg;
    assign link.snoop_modified_match_cs_n = ~snoop_modified_match_reg;
    assign nmi_o = nmi_reg;
    assign fp_error_seen_o = ferr_reg;
    assign dev_stall_o = stall_reg;
    assign internal_fault_seen_o = internal_fault_out_reg;
endmodule // fault_sig_chipset
`default_nettype wire

// *** fault_sig_checker.sv ***
// checker for the wires that join the processor end and the chipset end
// assumes one clock; instantiated beside the link interface, no bind
`timescale 1ns/1ps
`default_nettype none
module fault_sig_checker (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic fp_fault_or_break_pending_n,
    input wire logic stop_clock_request_n,
    input wire logic debug_probe_request_n,
    input wire logic internal_fault_out_n,
    input wire logic bus_restart_in_n,
    input wire logic init_n,
    input wire logic shutdown_txn,
    input wire logic snoop_hit_dev_n,
    input wire logic snoop_modified_match_dev_n
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    // a break needs two stopped samples: an fp error already showing
    // when the stop begins is not a break and may drop at once
    sequence brk_s;
        !stop_clock_request_n && $past(!stop_clock_request_n) && !fp_fault_or_break_pending_n;
    endsequence
    // last stall cycle followed by the one result cycle
    sequence stall_end_s;
        (!snoop_hit_dev_n && !snoop_modified_match_dev_n)
            ##1 (snoop_hit_dev_n || snoop_modified_match_dev_n);
    endsequence
    a_break_holds: assert property (brk_s |=> !fp_fault_or_break_pending_n)
        else $error("break dropped early");
    a_stop_released: assert property (brk_s |=> stop_clock_request_n)
        else $error("stop-clock kept after break");
    a_probe_breaks: assert property (!stop_clock_request_n
        && $past(!stop_clock_request_n) && !debug_probe_request_n
        |=> !fp_fault_or_break_pending_n) else $error("probe under stop gave no break");
    // fault pin latches until a restart or init is seen
    a_fault_held: assert property (!internal_fault_out_n
        && bus_restart_in_n && init_n |=> !internal_fault_out_n)
        else $error("internal fault released early");
    a_shutdown_fault: assert property (shutdown_txn |-> $fell(internal_fault_out_n))
        else $error("shutdown without new fault");
    a_fault_shutdown: assert property ($fell(internal_fault_out_n) |-> shutdown_txn)
        else $error("fault without shutdown");
    a_shutdown_pulse: assert property (shutdown_txn |=> !shutdown_txn)
        else $error("shutdown longer than one cycle");
    a_stall_result: assert property (stall_end_s
        |=> snoop_hit_dev_n && snoop_modified_match_dev_n)
        else $error("result after stall not single");
endmodule // fault_sig_checker
`default_nettype wire

// *** fp_error_break_event_signals_bench.sv ***
// self-checking bench: device and chipset ends face each other over the link
// assumes package, header and interface compiled first
`timescale 1ns/1ps
`default_nettype none
module fp_error_break_event_signals_bench;
    logic core_clk_i = 0, reset_n_i = 0, fe = 0, fm = 0, rb = 0, op = 0, ie = 0;
    logic sq = 0, sh = 0, sm = 0, sb = 0, stp = 0, prb = 0, ign = 0, rsq = 0, ini = 0;
    logic nmie = 0, cst = 0, chit = 0, cmod = 0, h, m;
    logic exc, brk, nmi, fes, dst, ifs;
    logic [1:0] cs [3] = '{2'b00, 2'b11, 2'b10};
    logic [2:0] ct [3] = '{3'b100, 3'b010, 3'b001};
    int miscompares = 0, check_count = 0, n, k, c;
    fault_sig_if lk ();
    logic [1:0] dvp, csp;
    assign dvp = {lk.snoop_hit_dev_n, lk.snoop_modified_match_dev_n};
    assign csp = {lk.snoop_hit_cs_n, lk.snoop_modified_match_cs_n};
    fault_sig_device fault_sig_device_i (.core_clk_i, .reset_n_i, .link(lk), .fp_error_i(fe),
        .fp_error_masked_i(fm), .fp_report_mode_bit_i(rb), .fp_noncontrol_op_i(op),
        .internal_error_i(ie), .snoop_req_i(sq), .snoop_hit_i(sh), .snoop_modified_i(sm),
        .snoop_busy_i(sb), .fp_exception_o(exc), .break_pending_o(brk));
    fault_sig_chipset fault_sig_chipset_i (.core_clk_i, .reset_n_i, .link(lk), .stop_req_i(stp),
        .probe_req_i(prb), .ignore_req_i(ign), .restart_req_i(rsq), .init_req_i(ini),
        .nmi_enable_i(nmie), .snoop_stall_i(cst), .snoop_hit_i(chit), .snoop_modified_i(cmod),
        .nmi_o(nmi), .fp_error_seen_o(fes), .dev_stall_o(dst), .internal_fault_seen_o(ifs));
    fault_sig_checker fault_sig_checker_i (.core_clk_i, .reset_n_i,
        .fp_fault_or_break_pending_n(lk.fp_fault_or_break_pending_n),
        .stop_clock_request_n(lk.stop_clock_request_n), .init_n(lk.init_n),
        .debug_probe_request_n(lk.debug_probe_request_n), .shutdown_txn(lk.shutdown_txn),
        .internal_fault_out_n(lk.internal_fault_out_n), .bus_restart_in_n(lk.bus_restart_in_n),
        .snoop_hit_dev_n(lk.snoop_hit_dev_n),
        .snoop_modified_match_dev_n(lk.snoop_modified_match_dev_n));
    always #25 core_clk_i = ~core_clk_i;
    // active-low result pair for a hit and modified outcome
    function automatic logic [1:0] pins(logic hit, logic mod);
        return {~hit, ~mod};
    endfunction
    task automatic check(string what, logic [1:0] seen, logic [1:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // watchdog: the whole sequence needs well under 1000 cycles
    initial begin
        #200000;
        miscompares++;
        final_report();
    end
    initial begin
        void'($urandom(96324));
        repeat (2) @(posedge core_clk_i);
        reset_n_i <= 1;
        @(negedge core_clk_i);
        check("idle", {lk.fp_fault_or_break_pending_n, lk.shutdown_txn}, 2'b10);
        // masked error refused, unmasked error shown next cycle
        for (k = 0; k < 2; k++) begin
            @(posedge core_clk_i) {fe, fm} <= {1'b1, k == 0};
            @(posedge core_clk_i) fe <= 0;
            @(negedge core_clk_i);
            check("ferr", lk.fp_fault_or_break_pending_n, k == 0);
            @(negedge core_clk_i) check("fp seen", fes, k != 0);
        end
        // ignore and report-bit combinations against a stored error
        for (k = 0; k < 3; k++) begin
            @(posedge core_clk_i) {ign, rb} <= cs[k];
            repeat (3) @(posedge core_clk_i);
            op <= 1;
            @(posedge core_clk_i) op <= 0;
            @(negedge core_clk_i);
            check("exception", exc, cs[k] != 2'b10);
        end
        repeat (2) @(negedge core_clk_i);
        check("ferr cleared", lk.fp_fault_or_break_pending_n, 1);
        check("fp seen cleared", fes, 0);
        $display("fp error test done");
        // probe under stop-clock, chipset then lets the device run
        @(posedge core_clk_i) {ign, stp} <= 2'b01;
        repeat (4) @(posedge core_clk_i);
        prb <= 1;
        for (c = 0; c < 10 && brk !== 1'b1; c++) @(negedge core_clk_i);
        check("break", {brk, lk.fp_fault_or_break_pending_n}, 2'b10);
        for (c = 0; c < 10 && lk.stop_clock_request_n !== 1'b1; c++) @(negedge core_clk_i);
        check("stop released", lk.stop_clock_request_n, 1);
        @(posedge core_clk_i) {stp, prb} <= 2'b00;
        @(negedge core_clk_i) check("restop", {lk.stop_clock_request_n, fes}, 2'b10);
        repeat (2) @(negedge core_clk_i);
        check("break gone", {brk, lk.fp_fault_or_break_pending_n}, 2'b01);
        $display("break test done");
        // internal fault, cleared by restart then by init
        for (k = 0; k < 2; k++) begin
            @(posedge core_clk_i) {ie, nmie} <= {1'b1, k == 0};
            @(posedge core_clk_i) ie <= 0;
            @(negedge core_clk_i);
            check("fault", {lk.internal_fault_out_n, lk.shutdown_txn}, 2'b01);
            @(negedge core_clk_i) check("nmi", nmi, k == 0);
            repeat (4) @(negedge core_clk_i);
            check("fault held", {lk.internal_fault_out_n, ifs}, 2'b01);
            @(posedge core_clk_i) {ini, rsq} <= k ? 2'b10 : 2'b01;
            repeat (3) @(posedge core_clk_i);
            {ini, rsq} <= 2'b00;
            repeat (2) @(negedge core_clk_i);
            check("fault cleared", lk.internal_fault_out_n, 1);
        end
        $display("internal fault test done");
        // device snoop result, stalls of random length, first one without stall
        for (k = 0; k < 6; k++) begin
            n = k ? 2 + $urandom_range(2) : 0;
            h = 1'($urandom_range(1));
            m = h ? 1'b0 : 1'($urandom_range(1));
            @(posedge core_clk_i) {sq, sb, sh, sm} <= {1'b1, n != 0, h, m};
            @(posedge core_clk_i) sq <= 0;
            @(negedge core_clk_i);
            check("snoop first", dvp, n ? 2'b00 : pins(h, m));
            @(negedge core_clk_i) check("stall seen", dst, n != 0);
            if (n) begin
                repeat (n) @(posedge core_clk_i);
                sb <= 0;
                for (c = 0; c < 8; c++) begin
                    @(negedge core_clk_i);
                    if (dvp !== 2'b00) break;
                end
                check("snoop result", dvp, pins(h, m));
            end
        end
        // chipset side: stall code, then each result line
        for (k = 0; k < 3; k++) begin
            @(posedge core_clk_i) {cst, chit, cmod} <= ct[k];
            @(posedge core_clk_i);
            @(negedge core_clk_i);
            check("cs snoop", csp, ct[k][2] ? 2'b00 : ~ct[k][1:0]);
        end
        $display("snoop test done");
        final_report();
    end
endmodule // fp_error_break_event_signals_bench
`default_nettype wire
